/* File: pcfd_defines.svh */
`ifndef PCFD_DEFINES_SVH
`define PCFD_DEFINES_SVH
// ****************************************
// Register map and pages
// ****************************************
`define PCFD_OFS_LEN 5'h14
`define PCFD_OFS_SD 5'h1E
`define PCFD_OFS_CFG 5'h1F
`define PCFD_PAGE_CFG 3'h0
`define PCFD_PAGE_TEST 3'h1
`define PCFD_PAGE_DIAG 3'h2
// ****************************************
// Field positions
// ****************************************
`define PCFD_B_ERR 15
`define PCFD_B_GOOD 14
`define PCFD_B_DASEL 8
`define PCFD_B_IRQ_HI 7
`define PCFD_B_IRQ_LO 6
`define PCFD_B_BCREJ 5
`define PCFD_B_DEP_HI 4
`define PCFD_B_DEP_LO 1
`define PCFD_B_WREN 0
`define PCFD_B_FAST 8
`define PCFD_MCAST_BIT 40
// ****************************************
// Reset values and masks
// ****************************************
`define PCFD_SD_RESET 16'h8000
`define PCFD_SD_WMASK 16'hF7FF
`define PCFD_LEN_RESET 8'hFF
`define PCFD_BCAST_PHY 5'h1F
// ****************************************
// Timing
// ****************************************
`define PCFD_CLK_KHZ 20000
`define PCFD_FAST_LOSS_NS 1000
`define PCFD_SLOW_LOSS_US 250
`define PCFD_FAST_CYC ((`PCFD_FAST_LOSS_NS * `PCFD_CLK_KHZ) / 1000000)
`define PCFD_SLOW_CYC ((`PCFD_SLOW_LOSS_US * `PCFD_CLK_KHZ) / 1000)
`define PCFD_DEP_UNIT 4
`define PCFD_LINE_LEN 60
`endif

/* File: pcfd_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Transmitting side: eight nibbles 8 down to 1 per packet
// ****************************************
module pcfd_mac_model (
    // Clock and command
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic go,
    // Transmit nibble stream
    output logic tx_en,
    output logic [3:0] tx_d
);
    logic [3:0] cnt_ff;
    logic run;
    assign run = go || cnt_ff > 4'h1;
    // Idle data flips each cycle so a stale nibble never looks valid
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cnt_ff <= 4'h0;
            tx_en <= 1'b0;
            tx_d <= 4'h0;
        end else begin
            cnt_ff <= go ? 4'h8 : cnt_ff - {3'h0, cnt_ff != 4'h0};
            tx_en <= run;
            tx_d <= run ? (go ? 4'h8 : cnt_ff - 4'h1) : ~tx_d;
        end
    end
endmodule : pcfd_mac_model
`default_nettype wire

/* File: pcfd_pkg.sv */
package pcfd_pkg;
    typedef struct packed {
        logic err;
        logic good;
        logic da_sel;
        logic [1:0] irq_ctl;
        logic bc_rej;
        logic [3:0] depth;
        logic wr_en;
        logic [15:0] sd_cfg;
        logic [7:0] cable;
        logic [15:0] rdata;
        logic [1:0] sd_sync;
        logic [1:0] strap_sync;
        logic strap_load;
        logic [12:0] loss_cnt;
        logic sig_ok;
        logic hit;
        logic trunc;
        logic [59:0][4:0] line;
        logic out_en;
        logic [3:0] out_d;
    } pcfd_state_t;
endpackage : pcfd_pkg

/* File: pcfd_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcfd_defines.svh"
// Operation
// - A control frame received with an error sets bit 15, held until the config register is read.
// - A control frame finished without error sets bit 14, cleared by a read of the config register.
// - Bits 13 to 9 of the config register ignore writes and read zero.
// - Bit 8 picks which of two fixed destination addresses marks a control frame.
// - The selected address with the multicast bit of its first octet set also matches.
// - The two-bit interrupt field routes frame interrupts: low bit on good frames, high bit on errors.
// - Broadcast PHY address 0x1F is accepted unless bit 5 asks for an exact own-address match.
// - The four-bit depth field sets how long every transmitted packet is delayed for detection.
// - With depth zero packets bypass the delay line and a control frame is cut after its destination address.
// - Bit 0 enables in-band register writes, resets from a strap and is writable afterwards.
// - Signal detect bit 8 picks a loss detection time of about 1 us instead of about 250 us.
// - In the signal detect register bit 15 resets to one, bit 11 reads zero, other bits reset zero.
// - The cable length estimate is read-only, eight bits, resetting to all ones for unknown.
module pcfd_regs
    import pcfd_pkg::*;
#(
    parameter logic [12:0] SLOW_CYC = 13'(`PCFD_SLOW_CYC),
    parameter logic [47:0] CF_ADDR_A = 48'h0A0B0C0D0E0E, // arbitrary value
    parameter logic [47:0] CF_ADDR_B = 48'h0A0B0C000000  // arbitrary value
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Management register port
    input wire logic [2:0] page_sel,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // Frame parser
    input wire logic dest_valid,
    input wire logic [47:0] dest_addr,
    input wire logic [4:0] frame_phy_addr,
    input wire logic [4:0] own_phy_addr,
    input wire logic frame_done_ok,
    input wire logic frame_done_err,
    output logic ctrl_frame_hit,
    output logic frame_write_enable,
    // Interrupt routing
    output logic frame_irq,
    output logic irq_replaces_rhf,
    // Transmit path
    input wire logic tx_en_in,
    input wire logic [3:0] tx_data_in,
    output logic tx_en_out,
    output logic [3:0] tx_data_out,
    // Signal detect and cable length
    input wire logic sig_detect_pin,
    output logic link_signal_ok,
    input wire logic length_meters_valid,
    input wire logic [7:0] length_meters_meas,
    // Strap
    input wire logic strap_frame_en_pin
);
    // ****************************************
    // Constants
    // ****************************************
    // Depth steps are whole groups of nibbles, so the line never needs a partial tap
    localparam logic [12:0] FAST_CYC = 13'(`PCFD_FAST_CYC);
    localparam logic [5:0] UNIT = 6'(`PCFD_DEP_UNIT);

    pcfd_state_t st_ff;
    pcfd_state_t nxt_st;

    // ****************************************
    // Register decode
    // ****************************************
    logic sel_cfg;
    logic sel_sd;
    logic sel_len;
    logic rd_cfg;
    logic wr_cfg;
    logic wr_sd;

    // ****************************************
    // Frame match
    // ****************************************
    logic [47:0] sel_addr;
    logic [47:0] sel_addr_mcast;
    logic da_ok;
    logic phy_bcast_ok;
    logic phy_ok;
    logic frame_match;

    // ****************************************
    // Delay line and loss timer
    // ****************************************
    logic depth_zero;
    logic [5:0] tap;
    logic [4:0] tap_word;
    logic [12:0] limit;
    logic loss_expired;

    // ****************************************
    // Read data
    // ****************************************
    logic [15:0] cfg_view;
    logic [15:0] rd_val;

    always_comb begin
        nxt_st = st_ff;

        // ****************************************
        // Register decode
        // ****************************************
        // Page and offset are both decoded, so an access on another page is ignored
        sel_cfg = (page_sel == `PCFD_PAGE_CFG) && (reg_addr == `PCFD_OFS_CFG);
        sel_sd = (page_sel == `PCFD_PAGE_TEST) && (reg_addr == `PCFD_OFS_SD);
        sel_len = (page_sel == `PCFD_PAGE_DIAG) && (reg_addr == `PCFD_OFS_LEN);
        rd_cfg = reg_rd && sel_cfg;
        wr_cfg = reg_wr && sel_cfg;
        wr_sd = reg_wr && sel_sd;

        // ****************************************
        // Destination and PHY address match
        // ****************************************
        sel_addr = st_ff.da_sel ? CF_ADDR_B : CF_ADDR_A;
        sel_addr_mcast = sel_addr | (48'h1 << `PCFD_MCAST_BIT);
        da_ok = (dest_addr == sel_addr) || (dest_addr == sel_addr_mcast);
        phy_bcast_ok = !st_ff.bc_rej && (frame_phy_addr == `PCFD_BCAST_PHY);
        phy_ok = (frame_phy_addr == own_phy_addr) || phy_bcast_ok;
        frame_match = dest_valid && da_ok && phy_ok;

        // ****************************************
        // Delay tap and loss limit
        // ****************************************
        depth_zero = (st_ff.depth == 4'h0);
        // Depth zero bypasses the line, so the tap is parked at a legal index
        tap = depth_zero ? 6'h00 : 6'(st_ff.depth * UNIT) - 6'h01;
        tap_word = st_ff.line[tap];
        limit = st_ff.sd_cfg[`PCFD_B_FAST] ? FAST_CYC : SLOW_CYC;
        loss_expired = (st_ff.loss_cnt >= limit - 13'h0001);

        // ****************************************
        // Read data
        // ****************************************
        // Reserved bits are built as zero and never come from storage
        cfg_view = 16'h0000;
        cfg_view[`PCFD_B_ERR] = st_ff.err;
        cfg_view[`PCFD_B_GOOD] = st_ff.good;
        cfg_view[`PCFD_B_DASEL] = st_ff.da_sel;
        cfg_view[`PCFD_B_IRQ_HI:`PCFD_B_IRQ_LO] = st_ff.irq_ctl;
        cfg_view[`PCFD_B_BCREJ] = st_ff.bc_rej;
        cfg_view[`PCFD_B_DEP_HI:`PCFD_B_DEP_LO] = st_ff.depth;
        cfg_view[`PCFD_B_WREN] = st_ff.wr_en;
        rd_val = 16'h0000;
        if (sel_cfg) begin
            rd_val = cfg_view;
        end else if (sel_sd) begin
            rd_val = st_ff.sd_cfg;
        end else if (sel_len) begin
            rd_val = {8'h00, st_ff.cable};
        end
        // Read data holds between reads, so a late look at the bus is safe
        if (reg_rd) begin
            nxt_st.rdata = rd_val;
        end

        // ****************************************
        // Register writes
        // ****************************************
        // Bits 15 to 9 of the config register are never stored
        if (wr_cfg) begin
            nxt_st.da_sel = reg_wdata[`PCFD_B_DASEL];
            nxt_st.irq_ctl = reg_wdata[`PCFD_B_IRQ_HI:`PCFD_B_IRQ_LO];
            nxt_st.bc_rej = reg_wdata[`PCFD_B_BCREJ];
            nxt_st.depth = reg_wdata[`PCFD_B_DEP_HI:`PCFD_B_DEP_LO];
            nxt_st.wr_en = reg_wdata[`PCFD_B_WREN];
        end
        if (wr_sd) begin
            nxt_st.sd_cfg = reg_wdata & `PCFD_SD_WMASK;
        end

        // ****************************************
        // Status flags
        // ****************************************
        // Clear on read, a new event in the same cycle wins so no frame is lost
        if (rd_cfg) begin
            nxt_st.err = 1'b0;
            nxt_st.good = 1'b0;
        end
        if (frame_done_err) begin
            nxt_st.err = 1'b1;
        end
        if (frame_done_ok) begin
            nxt_st.good = 1'b1;
        end

        // ****************************************
        // Control frame hit
        // ****************************************
        // One-cycle pulse, gated by wr_en, so no hit is flagged while writes are off
        if (frame_match) begin
            nxt_st.hit = st_ff.wr_en;
        end else begin
            nxt_st.hit = 1'b0;
        end

        // ****************************************
        // Truncation
        // ****************************************
        // Truncation holds until the frame ends
        if (!tx_en_in) begin
            nxt_st.trunc = 1'b0;
        end else if (frame_match && depth_zero) begin
            nxt_st.trunc = 1'b1;
        end

        // ****************************************
        // Transmit delay line
        // ****************************************
        // One register stage is always present, so depth zero still costs a cycle
        nxt_st.line = {st_ff.line[58:0], {tx_en_in, tx_data_in}};
        if (depth_zero) begin
            nxt_st.out_en = tx_en_in && !nxt_st.trunc;
            nxt_st.out_d = tx_data_in;
        end else begin
            nxt_st.out_en = tap_word[4];
            nxt_st.out_d = tap_word[3:0];
        end

        // ****************************************
        // Cable length
        // ****************************************
        // Cable length estimate, hardware updated only
        if (length_meters_valid) begin
            nxt_st.cable = length_meters_meas;
        end

        // ****************************************
        // Signal detect
        // ****************************************
        // Pins pass two flops; only the second one feeds the timer
        nxt_st.sd_sync = {st_ff.sd_sync[0], sig_detect_pin};
        nxt_st.strap_sync = {st_ff.strap_sync[0], strap_frame_en_pin};
        if (st_ff.sd_sync[1]) begin
            nxt_st.loss_cnt = 13'h0000;
            nxt_st.sig_ok = 1'b1;
        end else if (loss_expired) begin
            nxt_st.sig_ok = 1'b0;
        end else begin
            nxt_st.loss_cnt = st_ff.loss_cnt + 13'h0001;
        end

        // ****************************************
        // Strap
        // ****************************************
        // Strap captured on the first edge after reset release
        // A write in that same cycle loses to the strap
        nxt_st.strap_load = 1'b0;
        if (st_ff.strap_load) begin
            nxt_st.wr_en = st_ff.strap_sync[1];
        end

        // ****************************************
        // Reset
        // ****************************************
        // Synchronisers keep shifting in reset so the strap is settled at release
        if (!resetn) begin
            nxt_st = '0;
            nxt_st.sd_sync = {st_ff.sd_sync[0], sig_detect_pin};
            nxt_st.strap_sync = {st_ff.strap_sync[0], strap_frame_en_pin};
            nxt_st.strap_load = 1'b1;
            nxt_st.sd_cfg = `PCFD_SD_RESET;
            nxt_st.cable = `PCFD_LEN_RESET;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge ref_clk) begin
        st_ff <= nxt_st;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata = st_ff.rdata;
    assign ctrl_frame_hit = st_ff.hit;
    assign frame_write_enable = st_ff.wr_en;
    // ****************************************
    // Interrupt request
    // ****************************************
    // Level from the flags, so it drops on the edge that clears them
    assign frame_irq = (st_ff.irq_ctl[0] && st_ff.good) ||
        (st_ff.irq_ctl[1] && st_ff.err);
    assign irq_replaces_rhf = |st_ff.irq_ctl;
    // ****************************************
    // Transmit and link
    // ****************************************
    assign tx_en_out = st_ff.out_en;
    assign tx_data_out = st_ff.out_d;
    assign link_signal_ok = st_ff.sig_ok;
endmodule : pcfd_regs
`default_nettype wire

/* File: pcfd_regs_note_end.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: pcfd_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker for the config register slice
// ****************************************
module pcfd_regs_chk (
    // Clock, reset and register port
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [2:0] page_sel,
    input wire logic [4:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Frame events and results
    input wire logic dest_valid,
    input wire logic frame_done_ok,
    input wire logic frame_done_err,
    input wire logic ctrl_frame_hit,
    input wire logic frame_write_enable,
    input wire logic frame_irq,
    input wire logic irq_replaces_rhf,
    // Signal detect
    input wire logic sig_detect_pin,
    input wire logic link_signal_ok
);
    logic rd_cfg;
    assign rd_cfg = reg_rd && page_sel == 3'h0 && reg_addr == 5'h1F;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_ERR_FLAG: assert property (frame_done_err ##1 rd_cfg |=> reg_rdata[15])
        else $error("error flag missing");
    AST_GOOD_FLAG: assert property (frame_done_ok ##1 rd_cfg |=> reg_rdata[14])
        else $error("good flag missing");
    AST_CFG_RSVD: assert property (rd_cfg |=> reg_rdata[13:9] == 5'h00)
        else $error("config reserved bits not zero");
    AST_HIT_CAUSE: assert property (ctrl_frame_hit |-> $past(dest_valid))
        else $error("hit without address");
    AST_IRQ_ROUTE: assert property (!irq_replaces_rhf |-> !frame_irq)
        else $error("irq while routing off");
    AST_HIT_ENABLE: assert property (ctrl_frame_hit |-> $past(frame_write_enable))
        else $error("hit while writes disabled");
    // Restore only, in either mode: the fast and slow loss bounds are checked by the bench
    AST_LINK_BACK: assert property (sig_detect_pin [*4] |=> link_signal_ok)
        else $error("link not restored");
    AST_SD_B11: assert property (reg_rd && page_sel == 3'h1 &&
        reg_addr == 5'h1E |=> !reg_rdata[11])
        else $error("sd bit 11 set");
    AST_LEN_HI: assert property (reg_rd && page_sel == 3'h2 &&
        reg_addr == 5'h14 |=> reg_rdata[15:8] == 8'h00)
        else $error("length upper byte set");
    AST_IRQ_DROP: assert property (frame_irq && rd_cfg && !frame_done_ok && !frame_done_err |=> !frame_irq)
        else $error("irq not dropped by read");
endmodule : pcfd_regs_chk
bind pcfd_regs pcfd_regs_chk chk_u (.*);
`default_nettype wire

/* File: pcfd_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module pcfd_regs_tb;
    logic ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, dest_valid = 0, go = 0;
    logic frame_done_ok = 0, frame_done_err = 0, sig_detect_pin = 1, length_meters_valid = 0;
    logic strap_frame_en_pin = 1, tx_en_in, tx_en_out, ctrl_frame_hit, frame_write_enable;
    logic frame_irq, irq_replaces_rhf, link_signal_ok;
    logic [2:0] page_sel = 0;
    logic [4:0] reg_addr = 0, frame_phy_addr = 0, own_phy_addr = 5'h03;
    logic [15:0] reg_wdata = 0, reg_rdata;
    logic [47:0] dest_addr = 0;
    logic [3:0] tx_data_in, tx_data_out;
    logic [7:0] length_meters_meas = 0;
    int n_fail = 0, n_tests = 0;
    // Both match addresses are arbitrary values
    pcfd_regs #(.SLOW_CYC(13'h032), .CF_ADDR_A(48'h02000000A5A5), .CF_ADDR_B(48'h02000000B4B4))
        dut_u (.*);
    pcfd_mac_model mac_u (.ref_clk(ref_clk), .resetn(resetn), .go(go), .tx_en(tx_en_in),
        .tx_d(tx_data_in));
    initial forever #25 ref_clk = ~ref_clk;
    task tick; @(posedge ref_clk); #1; endtask : tick
    task wr(input logic [2:0] p, input logic [4:0] a, input logic [15:0] v);
        {page_sel, reg_addr, reg_wdata, reg_wr} = {p, a, v, 1'b1};
        tick;
        reg_wr = 1'b0;
        tick;
    endtask : wr
    task automatic rc(input logic [2:0] p, input logic [4:0] a, input logic [15:0] e,
        input string n);
        {page_sel, reg_addr, reg_rd} = {p, a, 1'b1};
        tick;
        reg_rd = 1'b0;
        `CHK(n, e, reg_rdata)
        tick;
    endtask : rc
    task ev(input logic e, input logic [1:0] ctl);
        wr(3'h0, 5'h1F, {8'h00, ctl, 6'h00});
        {frame_done_err, frame_done_ok} = {e, !e};
        tick;
        {frame_done_err, frame_done_ok} = 2'b00;
        `CHK("irq", ctl[e], frame_irq)
        `CHK("route", |ctl, irq_replaces_rhf)
        rc(3'h0, 5'h1F, {!e ? 2'b01 : 2'b10, 6'h00, ctl, 6'h00}, "flag");
        `CHK("irq clear", 1'b0, frame_irq)
        rc(3'h0, 5'h1F, {8'h00, ctl, 6'h00}, "flag clear");
    endtask : ev
    task hit(input logic [47:0] da, input logic [4:0] pa, input logic e, input string n);
        {dest_addr, frame_phy_addr, dest_valid} = {da, pa, 1'b1};
        tick;
        dest_valid = 1'b0;
        `CHK(n, e, ctrl_frame_hit)
        tick;
    endtask : hit
    task automatic dly(input logic [3:0] dep, input string n);
        int a = -1;
        int b = -1;
        wr(3'h0, 5'h1F, {11'h000, dep, 1'b0});
        go = 1'b1;
        for (int i = 0; i < 100; i++) begin
            tick;
            go = 1'b0;
            if (tx_en_in && a < 0) a = i;
            if (tx_en_out && b < 0) begin
                b = i;
                `CHK("out data", 4'h8, tx_data_out)
            end
        end
        `CHK(n, 32'(dep) * 4 + 1, b - a)
    endtask : dly
    task automatic sig(input logic [15:0] sd, input int lim, input string n);
        int c = 0;
        wr(3'h1, 5'h1E, sd);
        sig_detect_pin = 1'b0;
        while (link_signal_ok && c < 200) begin
            tick;
            c++;
        end
        `CHK(n, 1'b1, c >= lim && c <= lim + 4)
        sig_detect_pin = 1'b1;
        repeat (5) tick;
        `CHK("link back", 1'b1, link_signal_ok)
    endtask : sig
    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (6) @(posedge ref_clk);
        #1 resetn = 1'b1;
        repeat (2) tick;
        rc(3'h1, 5'h1E, 16'h8000, "sd reset");
        rc(3'h2, 5'h14, 16'h00FF, "len reset");
        rc(3'h0, 5'h1F, 16'h0001, "cfg strap");
        `CHK("wr enable", 1'b1, frame_write_enable)
        rc(3'h3, 5'h1F, 16'h0000, "unmapped");
        wr(3'h0, 5'h1F, 16'hFFFF);
        rc(3'h0, 5'h1F, 16'h01FF, "cfg rsvd");
        wr(3'h1, 5'h1E, 16'hFFFF);
        rc(3'h1, 5'h1E, 16'hF7FF, "sd rsvd");
        wr(3'h2, 5'h14, 16'h1234);
        rc(3'h2, 5'h14, 16'h00FF, "len ro");
        {length_meters_meas, length_meters_valid} = {8'h2A, 1'b1};
        tick;
        length_meters_valid = 1'b0;
        rc(3'h2, 5'h14, 16'h002A, "len meas");
        ev(1'b0, 2'b01);
        ev(1'b1, 2'b10);
        ev(1'b0, 2'b10);
        ev(1'b1, 2'b00);
        wr(3'h0, 5'h1F, 16'h0001);
        hit(48'h02000000A5A5, 5'h1F, 1'b1, "addr a");
        hit(48'h03000000A5A5, 5'h1F, 1'b1, "mcast");
        hit(48'h02000000B4B4, 5'h1F, 1'b0, "b unsel");
        wr(3'h0, 5'h1F, 16'h0121);
        hit(48'h02000000B4B4, 5'h1F, 1'b0, "bcast rej");
        hit(48'h03000000B4B4, 5'h03, 1'b1, "own phy");
        hit(48'h02000000B4B4, 5'h04, 1'b0, "other phy");
        wr(3'h0, 5'h1F, 16'h0100);
        hit(48'h02000000B4B4, 5'h03, 1'b0, "wr off");
        `CHK("wr enable off", 1'b0, frame_write_enable)
        dly(4'h2, "depth 2");
        dly(4'hF, "depth 15");
        dly(4'h0, "depth 0");
        go = 1'b1;
        tick;
        go = 1'b0;
        tick;
        {dest_addr, frame_phy_addr, dest_valid} = {48'h02000000A5A5, 5'h1F, 1'b1};
        tick;
        dest_valid = 1'b0;
        tick;
        `CHK("trunc", 2'b10, {tx_en_in, tx_en_out})
        repeat (10) tick;
        sig(16'h8100, 20, "fast loss");
        sig(16'h8000, 50, "slow loss");
        complete_run;
    end
    initial begin
        #100000;
        n_fail++;
        complete_run;
    end
endmodule : pcfd_regs_tb
`default_nettype wire
